// ### hw/sfp_cfg.svh
// Latency and timing constants for the slave FIFO port
`ifndef SFP_CFG_SVH
`define SFP_CFG_SVH
// Read strobe sampled to data on the bus, link cycles
`define SFP_RD_LAT 2
// Write strobe or address sampled to flag outputs, link cycles
`define SFP_FLAG_LAT 3
// Socket switch to thread ready, least and most link cycles
`define SFP_SSD_MIN 2
`define SFP_SSD_MAX 68
// Address width of the variant that switches threads without delay
`define SFP_NARROW_ADDR_W 2
// Host: read strobe issued to synchronised data usable, in host ticks
`define SFP_HOST_RD_LAT 4
// Host: ticks to wait after an address change before trusting flags
`define SFP_HOST_SETTLE 6
`endif

// ### hw/sfp_pkg.sv
// Shared types of the slave FIFO port
package sfp_pkg;
   typedef enum logic [1:0] {
      SFP_FLAG_EMPTY = 2'h0,
      SFP_FLAG_FULL = 2'h1,
      SFP_FLAG_PARTIAL = 2'h2
   } sfp_flag_mode_t;
   typedef enum logic [1:0] {
      SFP_OP_READ = 2'h0,
      SFP_OP_WRITE = 2'h1,
      SFP_OP_ZLP = 2'h2,
      SFP_OP_SWITCH = 2'h3
   } sfp_host_op_t;
   typedef enum logic [5:0] {
      SFP_H_IDLE = 6'h01,
      SFP_H_SETUP = 6'h02,
      SFP_H_CHECK = 6'h04,
      SFP_H_XFER = 6'h08,
      SFP_H_DRAIN = 6'h10,
      SFP_H_WAITRDY = 6'h20
   } sfp_host_state_t;
endpackage

// ### hw/sfp_link_if.sv
// Pins between the external master and the slave FIFO port
interface sfp_link_if #(
   parameter int DATA_W = 16,
   parameter int ADDR_W = 5
);
   logic link_clk;
   logic port_select_n;
   logic bus_drive_enable_n;
   logic read_strobe_n;
   logic write_strobe_n;
   logic packet_commit_n;
   logic socket_switch_n;
   logic [ADDR_W-1:0] fifo_select_lines;
   logic [DATA_W-1:0] dq_host_out;
   logic dq_host_oe;
   logic [DATA_W-1:0] dq_dev_out;
   logic dq_dev_oe;
   logic [DATA_W-1:0] dq;
   logic flag_a;
   logic flag_b;
   logic thread_ready;

   // Wire level of the shared data bus
   assign dq = dq_dev_oe ? dq_dev_out : dq_host_out;

   modport host(
      output link_clk, port_select_n, bus_drive_enable_n, read_strobe_n, write_strobe_n,
      output packet_commit_n, socket_switch_n, fifo_select_lines, dq_host_out, dq_host_oe,
      input dq, dq_dev_oe, flag_a, flag_b, thread_ready
   );
   modport dev(
      input link_clk, port_select_n, bus_drive_enable_n, read_strobe_n, write_strobe_n,
      input packet_commit_n, socket_switch_n, fifo_select_lines, dq,
      output dq_dev_out, dq_dev_oe, flag_a, flag_b, thread_ready
   );
endinterface

// ### hw/sfp_sync.sv
// Two-flop synchroniser for levels entering a clock domain
module sfp_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic ce,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sfp_sync_state_t;

   sfp_sync_state_t s;
   sfp_sync_state_t next_s;

   // First stage feeds only the second
   always_comb begin
      next_s = s;
      next_s.s1 = d;
      next_s.s2 = s.s1;
   end

   always_ff @(posedge clk) begin
      if (ce) begin
         s <= next_s;
      end
   end

   assign q = s.s2;
endmodule

// ### hw/sfp_host_end.sv
// External master end: drives the slave FIFO port from a command port
`include "sfp_cfg.svh"
module sfp_host_end #(
   parameter int DATA_W = 16,
   parameter int ADDR_W = 5,
   parameter int LEN_W = 8
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ce,
   sfp_link_if.host link,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire sfp_pkg::sfp_host_op_t cmd_op,
   input wire logic [ADDR_W-1:0] cmd_addr,
   input wire logic [LEN_W-1:0] cmd_len,
   input wire logic cmd_commit,
   input wire logic [DATA_W-1:0] wr_data,
   output logic wr_take,
   output logic [DATA_W-1:0] rd_data,
   output logic rd_valid
);
   localparam int RL = `SFP_HOST_RD_LAT;

   typedef struct packed {
      sfp_pkg::sfp_host_state_t st;
      sfp_pkg::sfp_host_op_t op;
      logic ph;
      logic [7:0] wait_cnt;
      logic [LEN_W-1:0] left;
      logic commit_last;
      logic [RL-1:0] pipe;
      logic cs_n;
      logic oe_n;
      logic rd_n;
      logic wr_n;
      logic pe_n;
      logic sw_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dout;
      logic doe;
      logic cmd_ready;
      logic wr_take;
      logic rd_valid;
      logic [DATA_W-1:0] rd_data;
   } sfp_host_state_s_t;

   sfp_host_state_s_t s;
   sfp_host_state_s_t next_s;
   logic [DATA_W+2:0] pins_sync;
   logic tick;
   logic issue_rd;
   logic dev_empty;
   logic dev_full;
   logic dev_ready;

   // Device outputs come from the link domain
   sfp_sync #(.W(DATA_W + 3)) u_pin_sync (
      .clk(core_clk),
      .ce(ce),
      .d({link.dq, link.flag_a, link.flag_b, link.thread_ready}),
      .q(pins_sync)
   );

   assign dev_empty = pins_sync[2];
   assign dev_full = pins_sync[1];
   assign dev_ready = pins_sync[0];

   // Sequencer; pins change only on the falling half of the link clock
   always_comb begin
      next_s = s;
      issue_rd = 1'b0;
      tick = s.ph;
      next_s.ph = !s.ph;
      next_s.wr_take = 1'b0;
      next_s.rd_valid = 1'b0;
      if (tick) begin
         case (s.st)
            sfp_pkg::SFP_H_IDLE: begin
               if (cmd_valid && s.cmd_ready) begin
                  next_s.addr = cmd_addr;
                  next_s.cs_n = 1'b0;
                  next_s.op = cmd_op;
                  next_s.left = cmd_len;
                  next_s.commit_last = cmd_commit;
                  next_s.wait_cnt = 8'(`SFP_HOST_SETTLE);
                  next_s.st = sfp_pkg::SFP_H_SETUP;
               end
            end
            sfp_pkg::SFP_H_SETUP: begin
               if (s.wait_cnt != 8'h00) begin
                  next_s.wait_cnt = s.wait_cnt - 8'h01;
               end else if (s.op == sfp_pkg::SFP_OP_SWITCH) begin
                  next_s.sw_n = 1'b0;
                  // Settle for the stale ready, then the longest switch delay
                  next_s.wait_cnt = 8'(`SFP_HOST_SETTLE + `SFP_SSD_MAX);
                  next_s.st = sfp_pkg::SFP_H_WAITRDY;
               end else if (s.op == sfp_pkg::SFP_OP_ZLP) begin
                  next_s.pe_n = 1'b0;
                  next_s.st = sfp_pkg::SFP_H_DRAIN;
               end else begin
                  next_s.oe_n = (s.op != sfp_pkg::SFP_OP_READ);
                  next_s.st = sfp_pkg::SFP_H_CHECK;
               end
            end
            sfp_pkg::SFP_H_CHECK: begin
               // Flow control before a burst
               if (s.op == sfp_pkg::SFP_OP_READ ? !dev_empty : !dev_full) begin
                  next_s.st = sfp_pkg::SFP_H_XFER;
               end
            end
            sfp_pkg::SFP_H_XFER: begin
               if (s.left != '0) begin
                  next_s.left = s.left - 1'b1;
                  if (s.op == sfp_pkg::SFP_OP_READ) begin
                     next_s.rd_n = 1'b0;
                     issue_rd = 1'b1;
                  end else begin
                     next_s.wr_n = 1'b0;
                     next_s.doe = 1'b1;
                     next_s.dout = wr_data;
                     next_s.wr_take = 1'b1;
                     next_s.pe_n = !(s.commit_last && s.left == LEN_W'(1));
                  end
               end else begin
                  next_s.rd_n = 1'b1;
                  next_s.wr_n = 1'b1;
                  next_s.pe_n = 1'b1;
                  next_s.doe = 1'b0;
                  next_s.st = sfp_pkg::SFP_H_DRAIN;
               end
            end
            sfp_pkg::SFP_H_WAITRDY: begin
               next_s.sw_n = 1'b1;
               // Give up after the longest delay so a thread never ready cannot hang us
               if (s.wait_cnt == 8'h00) begin
                  next_s.st = sfp_pkg::SFP_H_DRAIN;
               end else if (dev_ready && s.wait_cnt <= 8'(`SFP_SSD_MAX)) begin
                  next_s.st = sfp_pkg::SFP_H_DRAIN;
               end else begin
                  next_s.wait_cnt = s.wait_cnt - 8'h01;
               end
            end
            sfp_pkg::SFP_H_DRAIN: begin
               // Address held until commit and read data are done
               next_s.pe_n = 1'b1;
               if (s.pipe[RL-2:0] == '0) begin
                  next_s.cs_n = 1'b1;
                  next_s.oe_n = 1'b1;
                  next_s.st = sfp_pkg::SFP_H_IDLE;
               end
            end
            default: begin
               next_s.st = sfp_pkg::SFP_H_IDLE;
            end
         endcase
         // Read data returns a fixed number of ticks after its strobe
         next_s.pipe = {s.pipe[RL-2:0], issue_rd};
         if (s.pipe[RL-1]) begin
            next_s.rd_valid = 1'b1;
            next_s.rd_data = pins_sync[DATA_W+2:3];
         end
      end
      next_s.cmd_ready = (next_s.st == sfp_pkg::SFP_H_IDLE) && next_s.ph;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         s <= '0;
         s.st <= sfp_pkg::SFP_H_IDLE;
         s.cs_n <= 1'b1;
         s.oe_n <= 1'b1;
         s.rd_n <= 1'b1;
         s.wr_n <= 1'b1;
         s.pe_n <= 1'b1;
         s.sw_n <= 1'b1;
      end else if (ce) begin
         s <= next_s;
      end
   end

   // Pins and user outputs straight from state
   assign link.link_clk = s.ph;
   assign link.port_select_n = s.cs_n;
   assign link.bus_drive_enable_n = s.oe_n;
   assign link.read_strobe_n = s.rd_n;
   assign link.write_strobe_n = s.wr_n;
   assign link.packet_commit_n = s.pe_n;
   assign link.socket_switch_n = s.sw_n;
   assign link.fifo_select_lines = s.addr;
   assign link.dq_host_out = s.dout;
   assign link.dq_host_oe = s.doe;
   assign cmd_ready = s.cmd_ready;
   assign wr_take = s.wr_take;
   assign rd_data = s.rd_data;
   assign rd_valid = s.rd_valid;
endmodule

// ### hw/sfp_dev_end.sv
// Device end of the synchronous slave FIFO port, clocked by the link clock
`include "sfp_cfg.svh"
// How it works
// - Master selects, checks flag, enables, then reads; host end enables before its flag check
// - Output enable only gates bus drive
// - Read strobe advances pointer, presents next word
// - Read data appears two cycles after strobe
// - Burst read yields a word every edge
// - Enabled bus shows previously addressed FIFO data
// - Flags configurable: empty/full/partial, dedicated/current thread
// - Master never reads empty or writes full; host end checks the flag only once, before the whole burst
// - Write strobe stores word, advances write pointer
// - Flag reflects write after three cycles
// - Burst write captures a word every edge
// - Packet end comes with the final word
// - Address held steady while packet end active
// - Packet end alone commits zero-length packet
// - Socket switch raises ready within 2..68
// - Ready means room for producer, data consumer
// - Switch delay only with five-bit address; here with any address width except two bits
// - Switch delay counted in link clock cycles
// - Address change reaches data, flags after three; here data moves only on a read strobe
module sfp_dev_end #(
   parameter int DATA_W = 16,
   parameter int ADDR_W = 5,
   parameter int DEPTH = 8,
   parameter int WATERMARK = 6,
   parameter int SWITCH_DELAY = `SFP_SSD_MIN
) (
   sfp_link_if.dev link,
   input wire logic rst,
   input wire logic link_ce,
   input wire logic [3:0] flag_mode,
   input wire logic [1:0] flag_dedicated,
   input wire logic [2*ADDR_W-1:0] flag_thread,
   input wire logic [(1<<ADDR_W)-1:0] producer_mask,
   input wire logic dma_ok,
   output logic pkt_commit,
   output logic pkt_zero,
   output logic [ADDR_W-1:0] pkt_thread
);
   localparam int THREADS = 1 << ADDR_W;
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   localparam int SYNC_W = 1 + 4 + 2 + 2 * ADDR_W + THREADS + 1;
   localparam int SSD = (SWITCH_DELAY < `SFP_SSD_MIN) ? `SFP_SSD_MIN :
      (SWITCH_DELAY > `SFP_SSD_MAX) ? `SFP_SSD_MAX : SWITCH_DELAY;
   localparam bit NARROW = (ADDR_W == `SFP_NARROW_ADDR_W);

   typedef struct packed {
      logic [THREADS-1:0][DEPTH-1:0][DATA_W-1:0] mem;
      logic [THREADS-1:0][PW-1:0] wptr;
      logic [THREADS-1:0][PW-1:0] rptr;
      logic [THREADS-1:0][CW-1:0] fill;
      logic [ADDR_W-1:0] addr;
      logic [`SFP_RD_LAT:0][DATA_W-1:0] rdp;
      logic dq_oe;
      logic [`SFP_FLAG_LAT-1:0][1:0] fp;
      logic [6:0] sw_cnt;
      logic ready;
      logic commit;
      logic zero;
      logic [ADDR_W-1:0] commit_thread;
   } sfp_dev_state_t;

   sfp_dev_state_t s;
   sfp_dev_state_t next_s;
   logic [SYNC_W-1:0] cfg_sync;
   logic rst_l;
   logic [3:0] mode_l;
   logic [1:0] ded_l;
   logic [2*ADDR_W-1:0] thr_l;
   logic [THREADS-1:0] prod_l;
   logic dma_ok_l;
   logic sel;
   logic rd;
   logic wr;
   logic push;
   logic pop;
   logic [ADDR_W-1:0] fthr;
   logic thread_ok;

   // Flag condition of one FIFO for a given mode
   function automatic logic flag_eval(input logic [1:0] mode, input logic [CW-1:0] f);
      logic r;
      r = 1'b0;
      case (sfp_pkg::sfp_flag_mode_t'(mode))
         sfp_pkg::SFP_FLAG_EMPTY: r = (f == '0);
         sfp_pkg::SFP_FLAG_FULL: r = (f == CW'(DEPTH));
         sfp_pkg::SFP_FLAG_PARTIAL: r = (f >= CW'(WATERMARK));
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   // Reset and side configuration enter the link domain
   sfp_sync #(.W(SYNC_W)) u_cfg_sync (
      .clk(link.link_clk),
      .ce(link_ce),
      .d({rst, flag_mode, flag_dedicated, flag_thread, producer_mask, dma_ok}),
      .q(cfg_sync)
   );

   assign {rst_l, mode_l, ded_l, thr_l, prod_l, dma_ok_l} = cfg_sync;

   // Strobe decode, transfers, flags and socket switching
   always_comb begin
      next_s = s;
      fthr = '0;
      sel = !link.port_select_n;
      rd = sel && !link.read_strobe_n;
      wr = sel && !link.write_strobe_n;
      pop = rd && (s.fill[s.addr] != '0);
      push = wr && (s.fill[s.addr] != CW'(DEPTH));
      // Registered address steers data and flags
      next_s.addr = link.fifo_select_lines;
      next_s.dq_oe = !link.bus_drive_enable_n;
      next_s.commit = 1'b0;
      next_s.zero = 1'b0;
      // Read side: pop into a fixed-length pipeline
      if (pop) begin
         next_s.rdp[0] = s.mem[s.addr][s.rptr[s.addr]];
         next_s.rptr[s.addr] = s.rptr[s.addr] + 1'b1;
      end
      for (int k = 1; k <= `SFP_RD_LAT; k++) begin
         next_s.rdp[k] = s.rdp[k-1];
      end
      // Write side: store from the bus
      if (push) begin
         next_s.mem[s.addr][s.wptr[s.addr]] = link.dq;
         next_s.wptr[s.addr] = s.wptr[s.addr] + 1'b1;
      end
      next_s.fill[s.addr] = s.fill[s.addr] + CW'(push) - CW'(pop);
      // Packet end, with or without a final word
      if (sel && !link.packet_commit_n) begin
         next_s.commit = 1'b1;
         next_s.zero = !wr;
         next_s.commit_thread = s.addr;
      end
      // Flag pipeline from the current fill levels
      for (int i = 0; i < 2; i++) begin
         fthr = ded_l[i] ? thr_l[i*ADDR_W +: ADDR_W] : s.addr;
         next_s.fp[0][i] = flag_eval(mode_l[2*i +: 2], s.fill[fthr]);
      end
      for (int k = 1; k < `SFP_FLAG_LAT; k++) begin
         next_s.fp[k] = s.fp[k-1];
      end
      // Producer needs room, consumer needs data
      thread_ok = prod_l[s.addr] ? !flag_eval(sfp_pkg::SFP_FLAG_FULL, s.fill[s.addr]) :
         !flag_eval(sfp_pkg::SFP_FLAG_EMPTY, s.fill[s.addr]);
      // Delay counts link clock edges only
      if (!NARROW && sel && !link.socket_switch_n) begin
         next_s.sw_cnt = 7'(SSD - 1);
         next_s.ready = 1'b0;
      end else begin
         if (s.sw_cnt != 7'h00) begin
            next_s.sw_cnt = s.sw_cnt - 7'h01;
         end
         next_s.ready = (s.sw_cnt == 7'h00) && thread_ok && dma_ok_l;
      end
   end

   always_ff @(posedge link.link_clk) begin
      if (rst_l) begin
         s <= '0;
      end else if (link_ce) begin
         s <= next_s;
      end
   end

   // Pins and user outputs straight from state
   assign link.dq_dev_out = s.rdp[`SFP_RD_LAT];
   assign link.dq_dev_oe = s.dq_oe;
   assign link.flag_a = s.fp[`SFP_FLAG_LAT-1][0];
   assign link.flag_b = s.fp[`SFP_FLAG_LAT-1][1];
   assign link.thread_ready = s.ready;
   assign pkt_commit = s.commit;
   assign pkt_zero = s.zero;
   assign pkt_thread = s.commit_thread;
endmodule

// ### tb/sfp_link_props.sv
// Link checker for the slave FIFO port
module sfp_link_props #(
   parameter int DATA_W = 16,
   parameter int ADDR_W = 5
) (
   input wire logic link_clk,
   input wire logic rst,
   input wire logic port_select_n,
   input wire logic bus_drive_enable_n,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic packet_commit_n,
   input wire logic socket_switch_n,
   input wire logic [ADDR_W-1:0] fifo_select_lines,
   input wire logic [DATA_W-1:0] dq_dev_out,
   input wire logic dq_dev_oe,
   input wire logic flag_a,
   input wire logic flag_b,
   input wire logic thread_ready
);
   logic rd_act, wr_act, sw_act, link_ev;
   logic [ADDR_W-1:0] prev_addr;
   logic [3:0] settle;
   // Strobes qualified by select
   assign rd_act = !port_select_n && !read_strobe_n;
   assign wr_act = !port_select_n && !write_strobe_n;
   assign sw_act = !port_select_n && !socket_switch_n;
   assign link_ev = rd_act || wr_act || sw_act || !packet_commit_n
      || (fifo_select_lines != prev_addr);
   // Address history and settle count after reset
   always_ff @(posedge link_clk) begin
      prev_addr <= fifo_select_lines;
      if (rst) begin
         settle <= 4'h0;
      end else if (settle != 4'hF) begin
         settle <= settle + 4'h1;
      end
   end
   default clocking cb @(posedge link_clk); endclocking
   default disable iff (rst);
   // Flags move only three cycles after a write, read or new address
   property flag_quiet;
      (settle == 4'hF) && ($changed(flag_a) || $changed(flag_b)) |-> $past(link_ev, 4);
   endproperty
   AST_OE_ON: assert property (!bus_drive_enable_n |=> dq_dev_oe)
      else $error("bus not driven after enable");
   AST_OE_OFF: assert property (bus_drive_enable_n |=> !dq_dev_oe)
      else $error("bus driven while disabled");
   AST_RD_ONLY: assert property (!$past(rd_act, 3) |-> $stable(dq_dev_out))
      else $error("read data moved without a read");
   AST_RD_LAT: assert property (rd_act |-> ##3 $changed(dq_dev_out))
      else $error("read word late or missing");
   AST_FLAG_LAT: assert property (flag_quiet)
      else $error("flag moved at the wrong time");
   AST_SW_LOW: assert property (sw_act |=> !thread_ready [*2])
      else $error("ready too early after switch");
   AST_OE_FIRST: assert property (rd_act |-> $past(bus_drive_enable_n) == 1'b0)
      else $error("read before output enable");
   AST_PE_ADDR: assert property (!packet_commit_n |-> $stable(fifo_select_lines))
      else $error("address moved during packet end");
   AST_WR_DRIVE: assert property (wr_act |-> bus_drive_enable_n && !dq_dev_oe)
      else $error("device drives bus during write");
   cover property (rd_act ##1 rd_act);
   cover property (wr_act && !packet_commit_n);
   cover property (!port_select_n && !packet_commit_n && write_strobe_n);
   cover property (sw_act ##[2:68] thread_ready);
endmodule

// ### tb/testbench.sv
// Bench joining the host end and the device end over the link
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic dev_rst = 1'b1;
   logic cmd_valid = 1'b0;
   logic cmd_commit = 1'b0;
   logic dma_ok = 1'b1;
   sfp_pkg::sfp_host_op_t cmd_op = sfp_pkg::SFP_OP_READ;
   logic [4:0] cmd_addr = 5'h00;
   logic [7:0] cmd_len = 8'h00;
   logic [15:0] wr_data = 16'h0000;
   logic [3:0] flag_mode = 4'h4;
   logic [1:0] flag_dedicated = 2'h0;
   logic [9:0] flag_thread = 10'h000;
   logic [31:0] producer_mask = 32'hFFFFFFF7;
   logic cmd_ready, wr_take, rd_valid, pkt_commit, pkt_zero;
   logic commit_seen, commit_zero;
   logic [15:0] rd_data;
   logic [4:0] pkt_thread, commit_thread;
   int fail_count = 0;
   int total_checks = 0;
   sfp_link_if link_if ();
   sfp_host_end u_sfp_host_end (.core_clk(core_clk), .rst(rst), .ce(1'b1), .link(link_if.host),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
      .cmd_len(cmd_len), .cmd_commit(cmd_commit), .wr_data(wr_data), .wr_take(wr_take),
      .rd_data(rd_data), .rd_valid(rd_valid));
   sfp_dev_end u_sfp_dev_end (.link(link_if.dev), .rst(dev_rst), .link_ce(1'b1),
      .flag_mode(flag_mode), .flag_dedicated(flag_dedicated), .flag_thread(flag_thread),
      .producer_mask(producer_mask), .dma_ok(dma_ok), .pkt_commit(pkt_commit),
      .pkt_zero(pkt_zero), .pkt_thread(pkt_thread));
   sfp_link_props #(.DATA_W(16), .ADDR_W(5)) u_sfp_link_props (.link_clk(link_if.link_clk),
      .rst(dev_rst), .port_select_n(link_if.port_select_n),
      .bus_drive_enable_n(link_if.bus_drive_enable_n), .read_strobe_n(link_if.read_strobe_n),
      .write_strobe_n(link_if.write_strobe_n), .packet_commit_n(link_if.packet_commit_n),
      .socket_switch_n(link_if.socket_switch_n), .fifo_select_lines(link_if.fifo_select_lines),
      .dq_dev_out(link_if.dq_dev_out), .dq_dev_oe(link_if.dq_dev_oe), .flag_a(link_if.flag_a),
      .flag_b(link_if.flag_b), .thread_ready(link_if.thread_ready));
   // Core clock
   always #50 core_clk = ~core_clk;
   // Latch device commit pulses
   always @(posedge link_if.link_clk) begin
      if (pkt_commit === 1'b1) begin
         commit_seen <= 1'b1;
         commit_zero <= pkt_zero;
         commit_thread <= pkt_thread;
      end
   end
   task automatic chk1(input string what, input logic exp, input logic got);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic complete_run();
      if (fail_count == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // One command to completion; words are base, base+1, ...
   task automatic xfer(input sfp_pkg::sfp_host_op_t op, input logic [4:0] a,
         input logic [7:0] n, input logic c, input logic [15:0] base);
      int k;
      int guard;
      k = 0;
      guard = 0;
      commit_seen <= 1'b0;
      wr_data <= base;
      cmd_op <= op;
      cmd_addr <= a;
      cmd_len <= n;
      cmd_commit <= c;
      cmd_valid <= 1'b1;
      do begin
         @(posedge core_clk);
         guard++;
      end while (cmd_ready !== 1'b1 && guard < 100);
      cmd_valid <= 1'b0;
      do begin
         @(posedge core_clk);
         guard++;
         if (wr_take === 1'b1) begin
            k++;
            wr_data <= base + 16'(k);
         end
         if (rd_valid === 1'b1) begin
            chk16("read word", base + 16'(k), rd_data);
            k++;
         end
      end while (cmd_ready !== 1'b1 && guard < 2000);
      chk1("command done", 1'b1, cmd_ready);
      chk16("word count", {8'h00, n}, 16'(k));
   endtask
   // Burst write with packet end, then burst read back
   task automatic sc_burst();
      xfer(sfp_pkg::SFP_OP_WRITE, 5'h01, 8'h04, 1'b1, 16'h1100);
      chk1("commit pulse", 1'b1, commit_seen);
      chk1("commit zero", 1'b0, commit_zero);
      chk16("commit thread", 16'h0001, {11'h000, commit_thread});
      xfer(sfp_pkg::SFP_OP_READ, 5'h01, 8'h04, 1'b0, 16'h1100);
   endtask
   // Fill a thread to full, then drain it to empty
   task automatic sc_fill();
      xfer(sfp_pkg::SFP_OP_WRITE, 5'h02, 8'h08, 1'b0, 16'h2200);
      repeat (10) @(posedge core_clk);
      chk1("full flag", 1'b1, link_if.flag_b);
      chk1("empty flag", 1'b0, link_if.flag_a);
      xfer(sfp_pkg::SFP_OP_READ, 5'h02, 8'h08, 1'b0, 16'h2200);
      repeat (10) @(posedge core_clk);
      chk1("empty flag", 1'b1, link_if.flag_a);
      chk1("full flag", 1'b0, link_if.flag_b);
   endtask
   // Switch socket and judge ready after the longest delay
   task automatic sw_check(input logic [4:0] a, input logic exp);
      xfer(sfp_pkg::SFP_OP_SWITCH, a, 8'h00, 1'b0, 16'h0000);
      repeat (70) @(posedge link_if.link_clk);
      chk1("thread ready", exp, link_if.thread_ready);
   endtask
   // Consumer empty, producer with room, gated, consumer with data
   task automatic sc_switch();
      sw_check(5'h03, 1'b0);
      sw_check(5'h01, 1'b1);
      dma_ok <= 1'b0;
      sw_check(5'h01, 1'b0);
      dma_ok <= 1'b1;
      xfer(sfp_pkg::SFP_OP_WRITE, 5'h03, 8'h02, 1'b0, 16'h3300);
      sw_check(5'h03, 1'b1);
   endtask
   // Reconfigure flags under a second reset, then partial and dedicated full
   task automatic sc_modes();
      dev_rst <= 1'b1;
      flag_mode <= {sfp_pkg::SFP_FLAG_FULL, sfp_pkg::SFP_FLAG_PARTIAL};
      flag_dedicated <= 2'h2;
      flag_thread <= {5'h02, 5'h00};
      repeat (20) @(posedge core_clk);
      dev_rst <= 1'b0;
      repeat (20) @(posedge core_clk);
      xfer(sfp_pkg::SFP_OP_WRITE, 5'h05, 8'h06, 1'b0, 16'h5500);
      xfer(sfp_pkg::SFP_OP_WRITE, 5'h02, 8'h08, 1'b0, 16'h6600);
      xfer(sfp_pkg::SFP_OP_ZLP, 5'h05, 8'h00, 1'b0, 16'h0000);
      repeat (10) @(posedge core_clk);
      chk1("zero commit", 1'b1, commit_zero);
      chk16("zero thread", 16'h0005, {11'h000, commit_thread});
      chk1("partial flag", 1'b1, link_if.flag_a);
      chk1("dedicated full", 1'b1, link_if.flag_b);
   endtask
   // Cut a hang short
   initial begin
      repeat (40000) @(posedge core_clk);
      fail_count++;
      complete_run();
   end
   // Host reset, device reset with link clock running, then scenarios
   initial begin
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      repeat (20) @(posedge core_clk);
      dev_rst <= 1'b0;
      repeat (20) @(posedge core_clk);
      sc_burst();
      sc_fill();
      sc_switch();
      sc_modes();
      complete_run();
   end
endmodule
